// file: include/dbgcs_consts.svh
// constants of the debugger control and status registers
`ifndef DBGCS_CONSTS_SVH
`define DBGCS_CONSTS_SVH
// link command codes
`define DBGCS_CMD_RD_STAT 8'h02
`define DBGCS_CMD_WR_CTRL 8'h04
`define DBGCS_CMD_RD_CTRL 8'h05
// breakpoint opcode and acknowledge character
`define DBGCS_BP_OPCODE 8'h00
`define DBGCS_ACK_BYTE 8'hFF
// control register fields
`define DBGCS_CTL_DEBUG 3'h7
`define DBGCS_CTL_BPEN 3'h6
`define DBGCS_CTL_ACK 3'h5
`define DBGCS_CTL_RST 3'h0
`define DBGCS_CTL_RESET 8'h00
// whole control words with a fixed meaning
`define DBGCS_CTL_STOP 8'h81
`define DBGCS_CTL_GO 8'h41
`define DBGCS_CTL_RUN 8'h40
// status register fields
`define DBGCS_STA_DEBUG 3'h7
`define DBGCS_STA_HALT 3'h6
`define DBGCS_STA_UNPROT 3'h5
`define DBGCS_STA_RESET 8'h00
// device reset sequence timing
`define DBGCS_CLK_PERIOD_NS 8
`define DBGCS_RST_HOLD_NS 1000
`define DBGCS_RST_HOLD_CYC ((`DBGCS_RST_HOLD_NS + `DBGCS_CLK_PERIOD_NS - 1) / `DBGCS_CLK_PERIOD_NS)
`endif

// file: include/dbgcs_pkg.sv
// types of the debugger control and status registers
package dbgcs_pkg;
  // link command parser states
  typedef enum logic [0:0] {
    DBGCS_IDLE = 1'b0,
    DBGCS_WDATA = 1'b1
  } dbgcs_parse_t;
endpackage : dbgcs_pkg

// file: rtl/dbgcs_rst_seq.sv
// device reset sequencer that spares the debugger
`timescale 1ns/1ns
`default_nettype none
`include "dbgcs_consts.svh"
module dbgcs_rst_seq #(
  parameter int HOLD_CYCLES = `DBGCS_RST_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  // hold the device reset for a fixed count, then pulse done
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_reg <= '0;
    end else begin
      done <= 1'b0;
      if (busy) begin
        if (cnt_reg == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - CW'(1);
        end
      end else if (start) begin
        busy <= 1'b1;
        cnt_reg <= CW'(HOLD_CYCLES - 1);
      end
    end
  end
endmodule : dbgcs_rst_seq
`default_nettype wire

// file: rtl/dbgcs_regs.sv
// debugger control and status registers with their link command decode
// What this block does
// - writing 81H to control resets the device and leaves it in debug mode.
// - writing 41H to control resets the device, then runs with breakpoints on.
// - writing 40H in debug mode resumes execution, breakpoints stay enabled.
// - control bit 7 high stops instruction fetch; low is normal operation.
// - clearing control bit 7 lets the core resume fetching where it stopped.
// - a breakpoint opcode 00H with breakpoints enabled sets debug mode itself.
// - under read protect, writing 0 to bit 7 is ignored; only reset clears it.
// - control bit 6 enables breakpoints; reset 0; when 0 breakpoint is a no-op.
// - with control bit 5 set, a taken breakpoint sends FFH to the host.
// - control bit 0 resets the device but not the debugger registers.
// - bit 0 self-clears when its reset sequence ends; writing 0 does nothing.
// - status bit 7 reads 1 in debug mode, 0 in normal mode.
// - status bit 6 reads 1 while the device is in halt mode.
// - status bit 5 reads 0 when read protect is in force, else 1.
// - control resets to zero; bits 4 to 1 are reserved and read-only.
// - link command 04H plus a byte writes control; 05H reads it back.
// - link command 02H returns the status byte.
`timescale 1ns/1ns
`default_nettype none
`include "dbgcs_consts.svh"
module dbgcs_regs #(
  parameter int RST_HOLD_CYCLES = `DBGCS_RST_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic halt_mode,
  input wire logic flash_read_protect_option,
  output logic debug_mode_bit,
  output logic breakpoint_enable,
  output logic break_nop,
  output logic dev_reset
);
  logic break_acknowledge_enable;
  logic rst_bit_reg;
  dbgcs_pkg::dbgcs_parse_t parse_reg;
  logic ctl_wr;
  logic [7:0] ctl_wdata;
  logic bp_seen;
  logic bp_taken;
  logic ack_pend_reg;
  logic rd_pend_reg;
  logic [7:0] rd_data_reg;
  logic tx_free;
  logic seq_start;
  logic seq_busy;
  logic seq_done;
  logic [7:0] ctl_view;
  logic [7:0] sta_view;

  // control readback, reserved bits forced to zero
  function automatic logic [7:0] ctl_word(input logic dm, input logic be,
                                          input logic ack, input logic rb);
    logic [7:0] w;
    w = `DBGCS_CTL_RESET;
    w[`DBGCS_CTL_DEBUG] = dm;
    w[`DBGCS_CTL_BPEN] = be;
    w[`DBGCS_CTL_ACK] = ack;
    w[`DBGCS_CTL_RST] = rb;
    return w;
  endfunction : ctl_word

  assign ctl_view = ctl_word(debug_mode_bit, breakpoint_enable,
                             break_acknowledge_enable, rst_bit_reg);

  // status word built from live state
  always_comb begin
    sta_view = `DBGCS_STA_RESET;
    sta_view[`DBGCS_STA_DEBUG] = debug_mode_bit;
    sta_view[`DBGCS_STA_HALT] = halt_mode;
    sta_view[`DBGCS_STA_UNPROT] = ~flash_read_protect_option;
  end

  // command 04H arms a data byte for control
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      parse_reg <= dbgcs_pkg::DBGCS_IDLE;
    end else if (rx_valid) begin
      case (parse_reg)
        dbgcs_pkg::DBGCS_IDLE: begin
          if (rx_data == `DBGCS_CMD_WR_CTRL) begin
            parse_reg <= dbgcs_pkg::DBGCS_WDATA;
          end
        end
        dbgcs_pkg::DBGCS_WDATA: begin
          parse_reg <= dbgcs_pkg::DBGCS_IDLE;
        end
        default: begin
          parse_reg <= dbgcs_pkg::DBGCS_IDLE;
        end
      endcase
    end
  end

  // the data byte after 04H is the control write
  assign ctl_wr = rx_valid && (parse_reg == dbgcs_pkg::DBGCS_WDATA);
  assign ctl_wdata = rx_data;

  // breakpoint opcode decoded by the core
  assign bp_seen = op_valid && (op_code == `DBGCS_BP_OPCODE);
  assign bp_taken = bp_seen && breakpoint_enable;

  // debug mode bit: set by write or breakpoint, the set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      debug_mode_bit <= 1'b0;
    end else if (bp_taken) begin
      debug_mode_bit <= 1'b1;
    end else if (ctl_wr) begin
      if (ctl_wdata[`DBGCS_CTL_DEBUG] || !flash_read_protect_option) begin
        // bit 7 selects debug or normal mode
        debug_mode_bit <= ctl_wdata[`DBGCS_CTL_DEBUG];
      end
    end
  end

  // breakpoint and acknowledge enables follow writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      breakpoint_enable <= 1'b0;
      break_acknowledge_enable <= 1'b0;
    end else if (ctl_wr) begin
      breakpoint_enable <= ctl_wdata[`DBGCS_CTL_BPEN];
      break_acknowledge_enable <= ctl_wdata[`DBGCS_CTL_ACK];
    end
  end

  // disabled breakpoint runs as a no-op
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      break_nop <= 1'b0;
    end else begin
      break_nop <= bp_seen && !breakpoint_enable;
    end
  end

  // reset request bit: a write of 1 beats the end-of-sequence clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_bit_reg <= 1'b0;
    end else if (ctl_wr && ctl_wdata[`DBGCS_CTL_RST]) begin
      rst_bit_reg <= 1'b1;
    end else if (seq_done) begin
      // self-clear at the end of the sequence
      rst_bit_reg <= 1'b0;
    end
  end

  // the sequencer's device reset does not reach the debugger registers, so bit 7 survives it
  assign seq_start = rst_bit_reg && !seq_busy && !seq_done;

  // device reset sequencer
  dbgcs_rst_seq #(
    .HOLD_CYCLES(RST_HOLD_CYCLES)
  ) u_rst_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(seq_start),
    .busy(seq_busy),
    .done(seq_done)
  );

  // device reset driven from the sequencer
  assign dev_reset = seq_busy;

  // transmit slot free when empty or being taken
  assign tx_free = !tx_valid || tx_ready;

  // acknowledge pending, a new breakpoint wins over the send
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_pend_reg <= 1'b0;
    end else if (bp_taken && break_acknowledge_enable) begin
      ack_pend_reg <= 1'b1;
    end else if (tx_free) begin
      ack_pend_reg <= 1'b0;
    end
  end

  // read commands capture the register byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_pend_reg <= 1'b0;
      rd_data_reg <= `DBGCS_STA_RESET;
    end else if (rx_valid && parse_reg == dbgcs_pkg::DBGCS_IDLE &&
                 rx_data == `DBGCS_CMD_RD_STAT) begin
      rd_pend_reg <= 1'b1;
      rd_data_reg <= sta_view;
    end else if (rx_valid && parse_reg == dbgcs_pkg::DBGCS_IDLE &&
                 rx_data == `DBGCS_CMD_RD_CTRL) begin
      rd_pend_reg <= 1'b1;
      rd_data_reg <= ctl_view;
    end else if (tx_free && !ack_pend_reg) begin
      rd_pend_reg <= 1'b0;
    end
  end

  // transmit holding register, acknowledge before read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= `DBGCS_STA_RESET;
    end else if (tx_free) begin
      if (ack_pend_reg) begin
        tx_valid <= 1'b1;
        tx_data <= `DBGCS_ACK_BYTE;
      end else if (rd_pend_reg) begin
        tx_valid <= 1'b1;
        tx_data <= rd_data_reg;
      end else begin
        tx_valid <= 1'b0;
      end
    end
  end

  // breakpoint stops fetch next cycle
  stop_on_bp_a: assert property (@(posedge clk_sys) disable iff (rst)
    bp_taken |=> debug_mode_bit)
    else $error("breakpoint did not enter debug mode");

  // disabled breakpoint is a no-op
  bp_nop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (bp_seen && !breakpoint_enable && !ctl_wr) |=>
      (break_nop && debug_mode_bit == $past(debug_mode_bit)))
    else $error("disabled breakpoint changed mode");

  // acknowledge only after an enabled breakpoint
  ack_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ack_pend_reg) |-> $past(bp_taken && break_acknowledge_enable))
    else $error("acknowledge without breakpoint");

  // pending acknowledge goes out as FFH
  ack_send_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ack_pend_reg && tx_free) |=> (tx_valid && tx_data == `DBGCS_ACK_BYTE))
    else $error("acknowledge byte not sent");

  // read protect keeps debug mode
  protect_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (flash_read_protect_option && debug_mode_bit) |=> debug_mode_bit)
    else $error("debug mode cleared under read protect");

  // 40H in debug mode resumes with breakpoints on
  resume_run_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_wr && ctl_wdata == `DBGCS_CTL_RUN && !flash_read_protect_option && !bp_taken) |=>
      (!debug_mode_bit && breakpoint_enable && !rst_bit_reg ##1 !dev_reset))
    else $error("run write did not resume");

  // reset request starts the sequence and spares debugger state
  rst_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(dev_reset) |-> ($past(rst_bit_reg, 1) && rst_bit_reg &&
      debug_mode_bit == $past(debug_mode_bit)))
    else $error("device reset without request");

  // end of sequence clears the request bit
  rst_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (seq_done && !(ctl_wr && ctl_wdata[`DBGCS_CTL_RST])) |=> !rst_bit_reg)
    else $error("reset bit not cleared");

  // status read captures live state
  stat_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_valid && parse_reg == dbgcs_pkg::DBGCS_IDLE && rx_data == `DBGCS_CMD_RD_STAT) |=>
      (rd_pend_reg && rd_data_reg == {$past(debug_mode_bit), $past(halt_mode),
                                      !$past(flash_read_protect_option), 5'h00}))
    else $error("status byte wrong");

  // control readback has zero reserved bits
  ctl_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_valid && parse_reg == dbgcs_pkg::DBGCS_IDLE && rx_data == `DBGCS_CMD_RD_CTRL) |=>
      (rd_data_reg[4:1] == 4'h0 && rd_data_reg[7] == $past(debug_mode_bit)))
    else $error("control readback wrong");

  // reset and stop write sets debug mode, then starts the device reset
  stop_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_wr && ctl_wdata == `DBGCS_CTL_STOP && !seq_busy) |=>
      (debug_mode_bit && rst_bit_reg ##1 dev_reset))
    else $error("stop write did not reset and halt");

  // reset and go write runs with breakpoints armed
  go_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_wr && ctl_wdata == `DBGCS_CTL_GO && !seq_busy && !flash_read_protect_option &&
     !bp_taken) |=> (!debug_mode_bit && breakpoint_enable && rst_bit_reg ##1 dev_reset))
    else $error("go write did not reset and run");

  // a set debug bit always lands
  debug_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_wr && ctl_wdata[`DBGCS_CTL_DEBUG]) |=> debug_mode_bit)
    else $error("debug mode not entered");

  // clearing the bit restarts fetch
  debug_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_wr && !ctl_wdata[`DBGCS_CTL_DEBUG] && !flash_read_protect_option && !bp_taken) |=>
      !debug_mode_bit)
    else $error("debug mode not left");

  // enable bit follows the written byte
  bp_enable_a: assert property (@(posedge clk_sys) disable iff (rst)
    ctl_wr |=> (breakpoint_enable == $past(ctl_wdata[`DBGCS_CTL_BPEN])))
    else $error("breakpoint enable not written");

  // no-op pulse only after a breakpoint opcode
  nop_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    !bp_seen |=> !break_nop)
    else $error("stray no-op pulse");

  // no acknowledge without an enabled breakpoint
  ack_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!ack_pend_reg && !(bp_taken && break_acknowledge_enable)) |=> !ack_pend_reg)
    else $error("acknowledge raised without cause");

  // device reset leaves debugger state alone
  keep_state_a: assert property (@(posedge clk_sys) disable iff (rst)
    (dev_reset && !ctl_wr && !bp_taken) |=>
      ($stable(debug_mode_bit) && $stable(breakpoint_enable)))
    else $error("device reset touched debugger state");

  // request bit stands until its sequence ends
  rst_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rst_bit_reg && !seq_done) |=> rst_bit_reg)
    else $error("reset request dropped early");

  // write command arms the data byte
  wr_arm_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_valid && parse_reg == dbgcs_pkg::DBGCS_IDLE && rx_data == `DBGCS_CMD_WR_CTRL) |=>
      (parse_reg == dbgcs_pkg::DBGCS_WDATA))
    else $error("write command not armed");
endmodule : dbgcs_regs
`default_nettype wire

// file: verif/dbgcs_host.sv
// link host model that sends command bytes and collects reply bytes
`timescale 1ns/1ns
`default_nettype none
module dbgcs_host (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic [7:0] got_q[$];
  // idle link at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5A;
    tx_ready = 1'b0;
  end
  task send(input logic [7:0] b);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~b;  // no stale byte left on the line
  endtask : send
  // accepts replies slowly at random
  always @(negedge clk_sys) begin
    tx_ready <= (($urandom % 3) == 0);
  end
  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready) got_q.push_back(tx_data);
  end
endmodule : dbgcs_host
`default_nettype wire

// file: verif/tb_top.sv
// testbench of the debugger control and status registers
`timescale 1ns/1ns
`default_nettype none
`include "dbgcs_consts.svh"
module tb_top;
  localparam int HOLD = 4;
  logic clk_sys, rst, op_valid, halt_mode, flash_read_protect_option;
  logic [7:0] op_code, rx_data, tx_data;
  logic rx_valid, tx_ready, tx_valid, debug_mode_bit, breakpoint_enable, break_nop, dev_reset;
  int n_fail, n_checks, cycles, ctrl_m, i;
  dbgcs_regs #(.RST_HOLD_CYCLES(HOLD)) dbgcs_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .op_valid(op_valid), .op_code(op_code), .halt_mode(halt_mode),
    .flash_read_protect_option(flash_read_protect_option), .debug_mode_bit(debug_mode_bit),
    .breakpoint_enable(breakpoint_enable), .break_nop(break_nop), .dev_reset(dev_reset));
  dbgcs_host dbgcs_host_inst (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
  // clock of 8 ns
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task do_reset();
    rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    ctrl_m = 0;
  endtask : do_reset
  // status byte expected from model and inputs
  function logic [7:0] stat_m();
    return {ctrl_m[7], halt_mode, ~flash_read_protect_option, 5'h00};
  endfunction : stat_m
  task read_back(input logic [7:0] cmd, input logic [7:0] exp);
    int k;
    logic [7:0] got;
    dbgcs_host_inst.send(cmd);
    for (k = 0; k < 60 && dbgcs_host_inst.got_q.size() == 0; k++) @(negedge clk_sys);
    got = 8'hXX;
    if (dbgcs_host_inst.got_q.size() > 0) got = dbgcs_host_inst.got_q.pop_front();
    check(got, exp);
  endtask : read_back
  task write_ctrl(input logic [7:0] v);
    int k;
    logic b7;
    dbgcs_host_inst.send(`DBGCS_CMD_WR_CTRL);
    dbgcs_host_inst.send(v);
    b7 = flash_read_protect_option ? (ctrl_m[7] | v[7]) : v[7];
    ctrl_m = {b7, v[6:5], 5'h00};
    @(negedge clk_sys);
    check({6'h00, debug_mode_bit, breakpoint_enable}, {6'h00, b7, v[6]});
    if (v[0]) begin
      for (k = 0; k < 10 && dev_reset !== 1'b1; k++) @(negedge clk_sys);
      for (k = 0; k < 200 && dev_reset === 1'b1; k++) @(negedge clk_sys);
      check(8'(k), 8'(HOLD));
    end
    read_back(`DBGCS_CMD_RD_CTRL, 8'(ctrl_m));
  endtask : write_ctrl
  task bp_op(input logic [7:0] code);
    int k;
    logic hit;
    hit = (code == `DBGCS_BP_OPCODE) && ctrl_m[6];
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_code = code;
    @(negedge clk_sys);
    op_valid = 1'b0;
    op_code = 8'($urandom);
    check({7'h00, break_nop}, {7'h00, code == 8'h00 && !ctrl_m[6]});
    if (hit) ctrl_m[7] = 1;
    check({7'h00, debug_mode_bit}, {7'h00, ctrl_m[7]});
    for (k = 0; k < 30 && dbgcs_host_inst.got_q.size() == 0; k++) @(negedge clk_sys);
    check(8'(dbgcs_host_inst.got_q.size()), {7'h00, hit && ctrl_m[5]});
    if (dbgcs_host_inst.got_q.size() > 0) check(dbgcs_host_inst.got_q.pop_front(), 8'hFF);
  endtask : bp_op
  // main sequence
  initial begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = 8'h00;
    halt_mode = 1'b0;
    flash_read_protect_option = 1'b0;
    void'($urandom(34));
    do_reset();
    check({4'h0, debug_mode_bit, breakpoint_enable, break_nop, dev_reset}, 8'h00);
    read_back(`DBGCS_CMD_RD_CTRL, 8'h00);
    for (i = 0; i < 4; i++) begin
      halt_mode = i[0];
      flash_read_protect_option = i[1];
      read_back(`DBGCS_CMD_RD_STAT, stat_m());
    end
    flash_read_protect_option = 1'b0;
    $display("test reset and status done");
    write_ctrl(8'h81);
    read_back(`DBGCS_CMD_RD_STAT, stat_m());
    write_ctrl(8'h40);
    write_ctrl(8'h41);
    $display("test control writes done");
    write_ctrl(8'h00);
    bp_op(8'h00);
    bp_op(8'h3C);
    write_ctrl(8'h60);
    bp_op(8'h00);
    write_ctrl(8'h40);
    bp_op(8'h00);
    $display("test breakpoints done");
    flash_read_protect_option = 1'b1;
    write_ctrl(8'h80);
    write_ctrl(8'h00);
    write_ctrl(8'h61);
    read_back(`DBGCS_CMD_RD_STAT, stat_m());
    do_reset();
    read_back(`DBGCS_CMD_RD_CTRL, 8'h00);
    flash_read_protect_option = 1'b0;
    $display("test read protect done");
    for (i = 0; i < 20; i++) begin
      halt_mode = 1'($urandom);
      write_ctrl(8'($urandom));
      read_back(`DBGCS_CMD_RD_STAT, stat_m());
    end
    $display("test random writes done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
